/* File: logic/seq_state_pkg.sv */
// Package of constants for the sequence state decoder
//
// Notes on behaviour
// - code 20 gives 93, 58, 4004h
// - code 23 gives 93, 13, 4004h
// - code 25 gives 78, blank, 0008h
// - code 27 gives 77, 106, 4008h
// - code 28 gives 66, blank, 0010h
// - code 29 gives 67, 72, 4010h
// - code 30 gives 95, blank, 0020h
// - code 31 gives 96, 58, 4020h
// - code 33 gives 77, 45, 4008h
// - code 34 gives 97, 98, 4020h
// - code 35 gives 83, blank, 0040h
// - code 36 gives 31, blank, 6000h
// - code 37 gives 111, blank, 6000h
// - code 38 gives 102, 105, 4002h
// - codes 39-43 give 102, 2-6, 0008h
// - code 44 gives blanks and A000h
// - code 45 gives 84, blank, 0080h
// - code 47 gives 79, blank, 0008h
// - codes 48, 49 give 68, blank, 0010h
// - state word flags phases by bit
// - nonzero fault code means lockout display
`default_nettype none
package seq_state_pkg;
   localparam int STATE_W = 8;
   localparam int FAULT_W = 8;
   localparam int STR_W = 8;
   localparam int BITS_W = 16;
   localparam logic [STR_W-1:0] STR_BLANK = 8'h00;
   localparam logic [STR_W-1:0] STR_LOCKOUT = 8'd52;
   localparam logic [STR_W-1:0] STR_UNKNOWN = 8'd31;
   localparam logic [BITS_W-1:0] BIT_INITIATE = 16'h0001;
   localparam logic [BITS_W-1:0] BIT_STANDBY = 16'h0002;
   localparam logic [BITS_W-1:0] BIT_PURGE = 16'h0004;
   localparam logic [BITS_W-1:0] BIT_PILOT = 16'h0008;
   localparam logic [BITS_W-1:0] BIT_MAIN = 16'h0010;
   localparam logic [BITS_W-1:0] BIT_RUN = 16'h0020;
   localparam logic [BITS_W-1:0] BIT_POSTPURGE = 16'h0040;
   localparam logic [BITS_W-1:0] BIT_PREIGN = 16'h0080;
   localparam logic [BITS_W-1:0] BIT_VALVE_PROVING = 16'h0100;
   localparam logic [BITS_W-1:0] BIT_ALARM = 16'h2000;
   localparam logic [BITS_W-1:0] BIT_HOLD = 16'h4000;
   localparam logic [BITS_W-1:0] BIT_LOCKOUT = 16'h8000;
   localparam logic [BITS_W-1:0] RESET_BITS = 16'h0000;
   localparam logic [STR_W-1:0] RESET_STR = 8'h00;
endpackage
`default_nettype wire

/* File: logic/seq_state_lut.sv */
// Combinational table from sequence state code to strings and state word
`default_nettype none
module seq_state_lut
   import seq_state_pkg::*;
(
   input wire logic [seq_state_pkg::STATE_W-1:0] state_code,
   output logic [seq_state_pkg::STR_W-1:0] line1,
   output logic [seq_state_pkg::STR_W-1:0] line2,
   output logic [seq_state_pkg::BITS_W-1:0] state_bits
);
   localparam logic [BITS_W-1:0] HOLD_INIT = BIT_HOLD | BIT_INITIATE;
   localparam logic [BITS_W-1:0] HOLD_STBY = BIT_HOLD | BIT_STANDBY;
   localparam logic [BITS_W-1:0] HOLD_PURGE = BIT_HOLD | BIT_PURGE;
   localparam logic [BITS_W-1:0] HOLD_PILOT = BIT_HOLD | BIT_PILOT;
   localparam logic [BITS_W-1:0] ALARM_ONLY = BIT_HOLD | BIT_ALARM;
   localparam logic [BITS_W-1:0] ALARM_LOCK = BIT_LOCKOUT | BIT_ALARM;

   always_comb begin
      line1 = STR_BLANK;
      line2 = STR_BLANK;
      state_bits = 16'h0000;
      // Codes outside the table read as all blank, no phase
      unique case (state_code)
         8'd1: begin line1 = 8'd48; state_bits = BIT_INITIATE; end
         8'd2: begin line1 = 8'd49; line2 = 8'd8; state_bits = HOLD_INIT; end
         8'd3: begin line1 = 8'd49; line2 = 8'd9; state_bits = HOLD_INIT; end
         8'd4: begin line1 = 8'd49; line2 = 8'd7; state_bits = HOLD_INIT; end
         8'd5: begin line1 = 8'd49; line2 = 8'd60; state_bits = HOLD_INIT; end
         8'd6: begin line1 = 8'd103; state_bits = BIT_STANDBY; end
         8'd7: begin line1 = 8'd104; line2 = 8'd94; state_bits = HOLD_STBY; end
         8'd8: begin line1 = 8'd104; line2 = 8'd106; state_bits = HOLD_STBY; end
         8'd9: begin line1 = 8'd104; line2 = 8'd35; state_bits = HOLD_STBY; end
         8'd10: begin line1 = 8'd104; line2 = 8'd86; state_bits = HOLD_STBY; end
         8'd11: begin line1 = 8'd104; line2 = 8'd101; state_bits = HOLD_STBY; end
         8'd12: begin line1 = 8'd104; line2 = 8'd54; state_bits = HOLD_STBY; end
         8'd13: begin line1 = 8'd104; line2 = 8'd13; state_bits = HOLD_STBY; end
         8'd14: begin line1 = 8'd93; line2 = 8'd40; state_bits = HOLD_PURGE; end
         8'd15: begin line1 = 8'd89; line2 = 8'd39; state_bits = HOLD_PURGE; end
         8'd16: begin line1 = 8'd93; line2 = 8'd98; state_bits = HOLD_PURGE; end
         8'd17: begin line1 = 8'd89; line2 = 8'd56; state_bits = HOLD_PURGE; end
         8'd18: begin line1 = 8'd93; line2 = 8'd35; state_bits = HOLD_PURGE; end
         8'd19: begin line1 = 8'd87; state_bits = BIT_PURGE; end
         8'd20: begin line1 = 8'd93; line2 = 8'd58; state_bits = HOLD_PURGE; end
         8'd21: begin line1 = 8'd93; line2 = 8'd101; state_bits = HOLD_PURGE; end
         8'd22: begin line1 = 8'd93; line2 = 8'd54; state_bits = HOLD_PURGE; end
         8'd23: begin line1 = 8'd93; line2 = 8'd13; state_bits = HOLD_PURGE; end
         8'd24: begin line1 = 8'd93; line2 = 8'd106; state_bits = HOLD_PURGE; end
         8'd25: begin line1 = 8'd78; state_bits = BIT_PILOT; end
         8'd26: begin line1 = 8'd77; line2 = 8'd98; state_bits = HOLD_PILOT; end
         8'd27: begin line1 = 8'd77; line2 = 8'd106; state_bits = HOLD_PILOT; end
         8'd28: begin line1 = 8'd66; state_bits = BIT_MAIN; end
         8'd29: begin line1 = 8'd67; line2 = 8'd72; state_bits = BIT_HOLD | BIT_MAIN; end
         8'd30: begin line1 = 8'd95; state_bits = BIT_RUN; end
         8'd31: begin line1 = 8'd96; line2 = 8'd58; state_bits = BIT_HOLD | BIT_RUN; end
         8'd32: begin line1 = 8'd77; line2 = 8'd46; state_bits = HOLD_PILOT; end
         8'd33: begin line1 = 8'd77; line2 = 8'd45; state_bits = HOLD_PILOT; end
         8'd34: begin line1 = 8'd97; line2 = 8'd98; state_bits = BIT_HOLD | BIT_RUN; end
         8'd35: begin line1 = 8'd83; state_bits = BIT_POSTPURGE; end
         8'd36: begin line1 = STR_UNKNOWN; state_bits = ALARM_ONLY; end
         8'd37: begin line1 = 8'd111; state_bits = ALARM_ONLY; end
         8'd38: begin line1 = 8'd102; line2 = 8'd105; state_bits = HOLD_STBY; end
         8'd39, 8'd40, 8'd41, 8'd42, 8'd43: begin
            line1 = 8'd102;
            line2 = state_code - 8'd37;
            state_bits = BIT_PILOT;
         end
         8'd44: state_bits = ALARM_LOCK;
         8'd45: begin line1 = 8'd84; state_bits = BIT_PREIGN; end
         8'd46: begin line1 = 8'd102; line2 = 8'd1; state_bits = BIT_PILOT; end
         8'd47: begin line1 = 8'd79; state_bits = BIT_PILOT; end
         8'd48, 8'd49: begin line1 = 8'd68; state_bits = BIT_MAIN; end
         8'd50: begin line1 = 8'd104; line2 = 8'd98; state_bits = HOLD_STBY; end
         8'd51, 8'd52, 8'd54, 8'd56, 8'd70: begin line1 = STR_UNKNOWN; state_bits = ALARM_LOCK; end
         8'd53: begin line1 = 8'd102; line2 = 8'd98; state_bits = HOLD_PILOT; end
         8'd55: begin line1 = 8'd104; line2 = 8'd92; state_bits = HOLD_STBY; end
         8'd57: begin line1 = 8'd93; line2 = 8'd92; state_bits = HOLD_PURGE; end
         8'd58: begin line1 = 8'd104; line2 = 8'd35; state_bits = HOLD_STBY; end
         8'd59: begin line1 = 8'd104; line2 = 8'd26; state_bits = HOLD_STBY; end
         8'd60, 8'd61, 8'd62, 8'd63, 8'd64, 8'd65, 8'd66: begin
            // Valve proof steps map to strings 210..216
            line1 = state_code + 8'd150;
            state_bits = BIT_HOLD | BIT_VALVE_PROVING;
         end
         8'd67: begin line1 = 8'd49; line2 = 8'd10; state_bits = HOLD_INIT; end
         8'd68: begin line1 = 8'd104; line2 = 8'd85; state_bits = HOLD_STBY; end
         8'd69: begin line1 = 8'd217; state_bits = ALARM_LOCK; end
         8'd71: begin line1 = 8'd22; line2 = 8'd23; state_bits = HOLD_STBY; end
         // Expanded annunciator rows: second line set for 72 and 73, left blank for 74 and 75
         8'd72: begin line1 = 8'd184; line2 = 8'd30; state_bits = HOLD_STBY; end
         8'd73: begin line1 = 8'd184; line2 = 8'd25; state_bits = HOLD_STBY; end
         8'd74: begin line1 = 8'd184; state_bits = HOLD_STBY; end
         8'd75: begin line1 = 8'd185; state_bits = HOLD_PURGE; end
         default: begin
            line1 = STR_BLANK;
            line2 = STR_BLANK;
            state_bits = 16'h0000;
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: logic/sequence_state_decoder.sv */
// Registered sequence state decoder with lockout override
`default_nettype none
module sequence_state_decoder
   import seq_state_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [seq_state_pkg::STATE_W-1:0] state_code,
   input wire logic [seq_state_pkg::FAULT_W-1:0] fault_code,
   output logic [seq_state_pkg::STR_W-1:0] line1_code,
   output logic [seq_state_pkg::STR_W-1:0] line2_code,
   output logic [seq_state_pkg::BITS_W-1:0] state_bits
);
   logic [STR_W-1:0] lut_line1;
   logic [STR_W-1:0] lut_line2;
   logic [BITS_W-1:0] lut_bits;
   logic [STR_W-1:0] line1_d;
   logic [STR_W-1:0] line2_d;
   logic [BITS_W-1:0] bits_d;
   logic [STR_W-1:0] line1_q;
   logic [STR_W-1:0] line2_q;
   logic [BITS_W-1:0] bits_q;

   seq_state_lut u_lut (
      .state_code(state_code),
      .line1(lut_line1),
      .line2(lut_line2),
      .state_bits(lut_bits)
   );

   // Fault string table lives elsewhere; fault code passed on line 2
   always_comb begin
      if (fault_code != '0) begin
         line1_d = STR_LOCKOUT;
         line2_d = fault_code;
         bits_d = BIT_LOCKOUT;
      end else begin
         line1_d = lut_line1;
         line2_d = lut_line2;
         bits_d = lut_bits;
      end
   end

   // Inputs come from logic on mclk, so no synchroniser
   always_ff @(posedge mclk) begin
      if (srst) begin
         line1_q <= RESET_STR;
         line2_q <= RESET_STR;
         bits_q <= RESET_BITS;
      end else begin
         line1_q <= line1_d;
         line2_q <= line2_d;
         bits_q <= bits_d;
      end
   end

   assign line1_code = line1_q;
   assign line2_code = line2_q;
   assign state_bits = bits_q;
endmodule
`default_nettype wire

/* File: verif/seq_decoder_checker.sv */
// Checker for the sequence state decoder
`default_nettype none
module seq_decoder_checker import seq_state_pkg::*; (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [seq_state_pkg::STATE_W-1:0] state_code,
   input wire logic [seq_state_pkg::FAULT_W-1:0] fault_code,
   input wire logic [seq_state_pkg::STR_W-1:0] line1_code,
   input wire logic [seq_state_pkg::STR_W-1:0] line2_code,
   input wire logic [seq_state_pkg::BITS_W-1:0] state_bits
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic ok;
   assign ok = fault_code == 8'h00;
   reset_clear_a: assert property (disable iff (1'b0) srst |=> {line1_code, line2_code, state_bits} == 32'h0)
      else $error("outputs not cleared by reset");
   lockout_word_a: assert property (!ok |=> state_bits == 16'h8000)
      else $error("lockout word wrong");
   lockout_text_a: assert property (!ok |=> line1_code == 8'h34 && line2_code == $past(fault_code))
      else $error("lockout strings wrong");
   purge_hold_a: assert property (ok && state_code == 8'h14 |=> {line1_code, line2_code} == 16'h5D3A)
      else $error("purge hold strings wrong");
   pilot_ign_a: assert property (ok && state_code == 8'h19 |=> state_bits == 16'h0008 && line1_code == 8'h4E)
      else $error("pilot ignition wrong");
   run_state_a: assert property (ok && state_code == 8'h1E |=> state_bits == 16'h0020 && line2_code == 8'h00)
      else $error("run state wrong");
   safety_step_a: assert property (ok && state_code inside {[8'h27:8'h2B]} |=>
      line1_code == 8'h66 && line2_code == $past(state_code) - 8'h25 && state_bits == 16'h0008)
      else $error("safety step wrong");
   blank_state_a: assert property (ok && state_code == 8'h2C |=> state_bits == 16'hA000 && line1_code == 8'h00)
      else $error("blank state wrong");
   cover property (!ok);
   cover property (ok && state_code == 8'h2B);
   cover property (disable iff (1'b0) $fell(srst));
endmodule
bind sequence_state_decoder seq_decoder_checker chk (.mclk(mclk), .srst(srst), .state_code(state_code),
   .fault_code(fault_code), .line1_code(line1_code), .line2_code(line2_code), .state_bits(state_bits));
`default_nettype wire

/* File: verif/burner_seq_model.sv */
// Model of the burner sequencer feeding state and fault codes
`default_nettype none
module burner_seq_model import seq_state_pkg::*; (
   output logic [seq_state_pkg::STATE_W-1:0] state_code,
   output logic [seq_state_pkg::FAULT_W-1:0] fault_code
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      state_code = 8'h00;
      fault_code = 8'h00;
   end
   // State field takes whatever state is given, also during lockout
   task automatic put(input logic [7:0] st, input logic [7:0] ft);
      state_code = st;
      fault_code = ft;
   endtask
endmodule
`default_nettype wire

/* File: verif/sequence_state_decoder_tb_top.sv */
// Self-checking bench for the sequence state decoder
`default_nettype none
module sequence_state_decoder_tb_top import seq_state_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [STATE_W-1:0] state_code;
   logic [FAULT_W-1:0] fault_code;
   logic [STR_W-1:0] line1_code;
   logic [STR_W-1:0] line2_code;
   logic [BITS_W-1:0] state_bits;
   int err_total = 0;
   int checks_done = 0;
   always #50 mclk = ~mclk;
   burner_seq_model src (.state_code(state_code), .fault_code(fault_code));
   sequence_state_decoder dut (.mclk(mclk), .srst(srst), .state_code(state_code), .fault_code(fault_code),
      .line1_code(line1_code), .line2_code(line2_code), .state_bits(state_bits));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Codes go in back to back, one per cycle
   task automatic apply(input logic [7:0] st, ft, l1, l2, input logic [15:0] bits);
      src.put(st, ft);
      @(posedge mclk);
      #1;
      chk({8'h00, line1_code}, {8'h00, l1});
      chk({8'h00, line2_code}, {8'h00, l2});
      chk(state_bits, bits);
   endtask
   task automatic t_table;
      apply(8'h14, 8'h00, 8'h5D, 8'h3A, 16'h4004);
      apply(8'h17, 8'h00, 8'h5D, 8'h0D, 16'h4004);
      apply(8'h19, 8'h00, 8'h4E, 8'h00, 16'h0008);
      apply(8'h1B, 8'h00, 8'h4D, 8'h6A, 16'h4008);
      apply(8'h1C, 8'h00, 8'h42, 8'h00, 16'h0010);
      apply(8'h1D, 8'h00, 8'h43, 8'h48, 16'h4010);
      apply(8'h1E, 8'h00, 8'h5F, 8'h00, 16'h0020);
      apply(8'h1F, 8'h00, 8'h60, 8'h3A, 16'h4020);
      apply(8'h21, 8'h00, 8'h4D, 8'h2D, 16'h4008);
      apply(8'h22, 8'h00, 8'h61, 8'h62, 16'h4020);
      apply(8'h23, 8'h00, 8'h53, 8'h00, 16'h0040);
      apply(8'h24, 8'h00, 8'h1F, 8'h00, 16'h6000);
      apply(8'h25, 8'h00, 8'h6F, 8'h00, 16'h6000);
      apply(8'h26, 8'h00, 8'h66, 8'h69, 16'h4002);
      for (int i = 0; i < 5; i++) apply(8'h27 + 8'(i), 8'h00, 8'h66, 8'h02 + 8'(i), 16'h0008);
      apply(8'h2C, 8'h00, 8'h00, 8'h00, 16'hA000);
      apply(8'h2D, 8'h00, 8'h54, 8'h00, 16'h0080);
      apply(8'h2F, 8'h00, 8'h4F, 8'h00, 16'h0008);
      apply(8'h30, 8'h00, 8'h44, 8'h00, 16'h0010);
      apply(8'h31, 8'h00, 8'h44, 8'h00, 16'h0010);
      apply(8'h3C, 8'h00, 8'hD2, 8'h00, 16'h4100);
      apply(8'hC8, 8'h00, 8'h00, 8'h00, 16'h0000);
      apply(8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
      apply(8'h01, 8'h00, 8'h30, 8'h00, 16'h0001);
      apply(8'h06, 8'h00, 8'h67, 8'h00, 16'h0002);
      apply(8'h42, 8'h00, 8'hD8, 8'h00, 16'h4100);
      apply(8'h45, 8'h00, 8'hD9, 8'h00, 16'hA000);
      apply(8'h4B, 8'h00, 8'hB9, 8'h00, 16'h4004);
   endtask
   task automatic t_lockout;
      apply(8'h14, 8'h05, 8'h34, 8'h05, 16'h8000);
      apply(8'h1E, 8'hFF, 8'h34, 8'hFF, 16'h8000);
      apply(8'h1E, 8'h00, 8'h5F, 8'h00, 16'h0020);
   endtask
   // Mid-run reset must win over a live state code
   task automatic t_reset;
      srst = 1'b1;
      src.put(8'h14, 8'h05);
      // Held over two edges: outputs must stay clear throughout
      repeat (2) begin
         @(posedge mclk);
         #1;
         chk({line1_code, line2_code}, 16'h0000);
         chk(state_bits, 16'h0000);
      end
      srst = 1'b0;
      apply(8'h1E, 8'h00, 8'h5F, 8'h00, 16'h0020);
   endtask
   task automatic results;
      if (err_total == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      #1 srst = 1'b0;
      t_table();
      t_lockout();
      t_reset();
      results();
   end
   // Whole run is under 60 cycles
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule
`default_nettype wire
